// ==== sfpfe_checker.sv ====
// Concurrent checks on the pin front end's top-level ports.
// Assumes one sys_clk domain with nrst asynchronous and active low.
module sfpfe_checker (
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic       chipSelN,
  input wire logic [3:0] dataLineIn,
  input wire logic [3:0] dataLineOen,
  input wire logic       quadEnableBit,
  input wire logic       quadInstructionMode,
  input wire logic       statusProtectBit,
  input wire logic       txDrive,
  input wire logic       txValid,
  input wire logic       txReady,
  input wire logic [7:0] rxData,
  input wire logic       rxValid,
  input wire logic       rxReady,
  input wire logic       frameActive,
  input wire logic       linkArmed,
  input wire logic       pauseActive,
  input wire logic       hwResetPulse,
  input wire logic       statusWriteBlocked
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Four cycles cover the select synchroniser
  a_desel_release: assert property (chipSelN [*4] |-> dataLineOen == 4'hf)
    else $error("data lines driven while deselected");
  a_pause_release: assert property (pauseActive |-> dataLineOen == 4'hf)
    else $error("data lines driven during pause");
  a_desel_nopause: assert property (chipSelN [*4] |-> !pauseActive)
    else $error("pause held while deselected");
  a_quad_nopause: assert property (quadEnableBit [*5] |-> !pauseActive)
    else $error("pause taken with quad enabled");
  a_quad_noreset: assert property (quadEnableBit [*5] |-> !hwResetPulse)
    else $error("line 3 reset taken with quad enabled");
  a_reset_disarm: assert property (hwResetPulse |=> !linkArmed && !frameActive)
    else $error("link still armed after hardware reset");
  a_wp_block: assert property ((!dataLineIn[2] && statusProtectBit && !quadEnableBit
      && !quadInstructionMode) [*5] |-> statusWriteBlocked)
    else $error("status write not blocked");
  a_quad_wp_off: assert property (quadEnableBit [*5] |-> !statusWriteBlocked)
    else $error("write protect active in quad mode");
  a_tx_pulse: assert property (txReady |-> txValid && txDrive ##1 !txReady)
    else $error("byte taken without request or pulse too long");
  a_rx_hold: assert property (rxValid && !rxReady |=> rxValid && $stable(rxData))
    else $error("received byte lost before pop");
endmodule // sfpfe_checker

bind sfpfe_top sfpfe_checker chk (
  .sys_clk, .nrst, .chipSelN, .dataLineIn, .dataLineOen, .quadEnableBit,
  .quadInstructionMode, .statusProtectBit, .txDrive, .txValid, .txReady,
  .rxData, .rxValid, .rxReady, .frameActive, .linkArmed, .pauseActive,
  .hwResetPulse, .statusWriteBlocked
);

// ==== sfpfe_defs.vh ====
// Constants shared by the serial flash pin front end.
// Assumes a 20 MHz system clock; times are in ns and cycles derive from them.
`ifndef SFPFE_DEFS_VH
`define SFPFE_DEFS_VH

`define SFPFE_SYS_CLK_PERIOD_NS 50
`define SFPFE_RESET_PULSE_MIN_NS 1000
`define SFPFE_RESET_PULSE_MIN_CYC \
  ((`SFPFE_RESET_PULSE_MIN_NS + `SFPFE_SYS_CLK_PERIOD_NS - 1) / `SFPFE_SYS_CLK_PERIOD_NS)

`define SFPFE_FIFO_DEPTH 8
`define SFPFE_FIFO_AW 3
`define SFPFE_FIFO_WIDTH 9

`define SFPFE_WIDTH_SINGLE 2'h0
`define SFPFE_WIDTH_DUAL 2'h1
`define SFPFE_WIDTH_QUAD 2'h2

`define SFPFE_BYTE_BITS 4'h8
`define SFPFE_OEN_SINGLE 4'hd
`define SFPFE_OEN_DUAL 4'hc
`define SFPFE_OEN_QUAD 4'h0
`define SFPFE_OEN_OFF 4'hf

`define SFPFE_LINE3_PAUSE 1'h0
`define SFPFE_LINE3_RESET 1'h1

`define SFPFE_SYNC_RST 1'h0
`define SFPFE_OUT_RST 4'h0

`endif

// ==== sfpfe_fifo.v ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock domain; full and empty come from an occupancy count.
module sfpfe_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             nrst,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_reg;
  reg [AW-1:0]    rdPtr_reg;
  reg [AW:0]      count_reg;
  wire            doWrite;
  wire            doRead;

  assign inReady  = (count_reg != DEPTH[AW:0]);
  assign outValid = (count_reg != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr_reg];
  assign doWrite  = inValid & inReady;
  assign doRead   = outValid & outReady;

  always @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr_reg <= {AW{1'b0}};
      rdPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (doWrite) begin
        wrPtr_reg <= (wrPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_reg + 1'b1;
      end
      if (doRead) begin
        rdPtr_reg <= (rdPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_reg + 1'b1;
      end
      if (doWrite & ~doRead) begin
        count_reg <= count_reg + 1'b1;
      end else if (doRead & ~doWrite) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule // sfpfe_fifo

// ==== sfpfe_host_model.sv ====
// Host controller model: makes the serial clock, select and host data lines.
// Assumes a 50 ns clk; a serial period is 8 clk cycles, clock idles low.
module sfpfe_host_model (
  input  wire logic       clk,
  input  wire logic [3:0] pins,
  output logic            linkClk,
  output logic            chipSelN,
  output logic [3:0]      hostData
);
  timeunit 1ns;
  timeprecision 1ns;
  // Select starts low so that arming needs an explicit high-to-low
  initial begin
    linkClk = 1'b0;
    chipSelN = 1'b0;
    hostData = 4'hf;
  end
  task automatic half();
    repeat (4) @(posedge clk);
  endtask
  task automatic select();
    chipSelN <= 1'b1;
    half();
    chipSelN <= 1'b0;
    half();
  endtask
  // Released lines flip so stale data never looks valid
  task automatic release_bus();
    half();
    chipSelN <= 1'b1;
    hostData <= ~hostData;
    half();
  endtask
  task automatic tick(input logic [3:0] d, output logic [3:0] s);
    hostData <= d;
    half();
    linkClk <= 1'b1;
    @(negedge clk);
    s = pins;
    half();
    linkClk <= 1'b0;
  endtask
  // w bits per clock, most significant group first
  task automatic xfer(input logic [7:0] b, input int w, output logic [7:0] r);
    logic [3:0] s;
    r = 8'h00;
    for (int k = 0; k < 8 / w; k++) begin
      case (w)
        1: tick({3'b111, b[7]}, s);
        2: tick({2'b11, b[7:6]}, s);
        default: tick(b[7:4], s);
      endcase
      b = b << w;
      case (w)
        1: r = {r[6:0], s[1]};
        2: r = {r[5:0], s[1:0]};
        default: r = {r[3:0], s};
      endcase
    end
  endtask
endmodule // sfpfe_host_model

// ==== sfpfe_top.v ====
// Pin front end of a serial NOR flash: line roles, sampling edges, select,
// write protect, pause and hardware reset on line 3.
// Assumes the serial clock is far slower than sys_clk (at least 8 samples per
// period); a command decoder on the user side sets the width and direction.
`include "sfpfe_defs.vh"

// Summary of operation
// - Incoming bits are captured on serial clock rising edges at any width.
// - Outgoing bits are driven on serial clock falling edges.
// - Chip select high deselects and releases every data line.
// - No instruction is taken before a high-to-low select after power-up.
// - Deselect does not abort a running internal erase, program or write.
// - Line 0 becomes bidirectional in dual and quad commands.
// - Line 1 becomes bidirectional in dual and quad commands.
// - Single and dual use lines 0 and 1; quad uses all four.
// - Low write protect with the status protect bit set blocks status writes and locks the protection settings.
// - Quad enable turns line 2 into a pure data line.
// - Select bit 0 makes line 3 an active-low pause input.
// - Pause while selected releases outputs and ignores clock and data.
// - Releasing pause resumes exactly where the transfer stopped.
// - Quad enable disables the pause function on line 3.
// - Select bit 1 makes line 3 an active-low hardware reset input.
// - Reset held low about 1 us aborts every operation.
// - Line 3 role follows select bit unless quad enable or quad-instruction mode makes it data.
// - Protect, pause and reset pins act only in single and dual operation.
// - Quad-instruction mode takes each instruction in 2 clocks.
// - Continuous read skips the instruction and starts with the address.
module sfpfe_top #(
  parameter RESET_CYC  = `SFPFE_RESET_PULSE_MIN_CYC,
  parameter FIFO_DEPTH = `SFPFE_FIFO_DEPTH,
  parameter FIFO_AW    = `SFPFE_FIFO_AW
) (
  input  wire       sys_clk,
  input  wire       nrst,
  input  wire       linkClk,
  input  wire       chipSelN,
  input  wire [3:0] dataLineIn,
  output wire [3:0] dataLineOut,
  output wire [3:0] dataLineOen,
  input  wire       quadEnableBit,
  input  wire       line3FunctionSelect,
  input  wire       quadInstructionMode,
  input  wire       statusProtectBit,
  input  wire [1:0] cmdWidth,
  input  wire       txDrive,
  input  wire       contRead,
  input  wire [7:0] txData,
  input  wire       txValid,
  output wire       txReady,
  output wire [7:0] rxData,
  output wire       rxInstr,
  output wire       rxValid,
  input  wire       rxReady,
  output wire       frameActive,
  output wire       linkArmed,
  output wire       pauseActive,
  output wire       hwResetPulse,
  output wire       statusWriteBlocked,
  output wire       rxOverrun
);

  // Bits carried per serial clock at a given width
  function [3:0] bitsPerClk;
    input [1:0] width;
    begin
      case (width)
        `SFPFE_WIDTH_DUAL: bitsPerClk = 4'h2;
        `SFPFE_WIDTH_QUAD: bitsPerClk = 4'h4;
        default:           bitsPerClk = 4'h1;
      endcase
    end
  endfunction

  // Output enables (low = driving) for a given width
  function [3:0] laneOen;
    input [1:0] width;
    begin
      case (width)
        `SFPFE_WIDTH_SINGLE: laneOen = `SFPFE_OEN_SINGLE;
        `SFPFE_WIDTH_DUAL:   laneOen = `SFPFE_OEN_DUAL;
        `SFPFE_WIDTH_QUAD:   laneOen = `SFPFE_OEN_QUAD;
        default:             laneOen = `SFPFE_OEN_OFF;
      endcase
    end
  endfunction

  // Synchronisers: first stage feeds only the second
  reg  [1:0] clkSync_reg;
  reg        clkPrev_reg;
  reg  [1:0] csSync_reg;
  reg        csPrev_reg;
  reg  [3:0] dMeta_reg;
  reg  [3:0] dSync_reg;

  reg        armed_reg;
  reg        frameOn_reg;
  reg        instrPhase_reg;
  reg        pause_reg;
  reg  [7:0] rstCnt_reg;
  reg        hwReset_reg;
  reg        wpBlock_reg;

  reg  [7:0] rxShift_reg;
  reg  [3:0] rxCnt_reg;
  reg  [8:0] push_reg;
  reg        pushValid_reg;
  reg        overrun_reg;

  reg  [7:0] txShift_reg;
  reg  [3:0] txCnt_reg;
  reg  [3:0] out_reg;

  wire       clkS;
  wire       csS;
  wire       linkRise;
  wire       linkFall;
  wire       csFall;
  wire       pinFnOn;
  wire       pauseFn;
  wire       resetFn;
  wire       pause_next;
  wire       liveEdges;
  wire [1:0] curWidth;
  wire [3:0] curBits;
  wire       rxTake;
  wire       txTake;
  wire       drive;
  wire       fifoInReady;
  wire [8:0] fifoOut;
  wire [3:0] rxCnt_next;
  wire [7:0] txSrc;
  wire [7:0] rxShift_next;

  assign clkS = clkSync_reg[1];
  assign csS  = csSync_reg[1];

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      clkSync_reg <= {2{`SFPFE_SYNC_RST}};
      clkPrev_reg <= `SFPFE_SYNC_RST;
      csSync_reg  <= {2{`SFPFE_SYNC_RST}};
      csPrev_reg  <= `SFPFE_SYNC_RST;
      dMeta_reg   <= `SFPFE_OUT_RST;
      dSync_reg   <= `SFPFE_OUT_RST;
    end else begin
      clkSync_reg <= {clkSync_reg[0], linkClk};
      clkPrev_reg <= clkS;
      csSync_reg  <= {csSync_reg[0], chipSelN};
      csPrev_reg  <= csS;
      dMeta_reg   <= dataLineIn;
      dSync_reg   <= dMeta_reg;
    end
  end

  // Data passes the same two stages as the clock, so edges and data line up
  assign linkRise = clkS & ~clkPrev_reg;
  assign linkFall = ~clkS & clkPrev_reg;
  // Reset values are low, so a select held low from power-up never looks like a fall
  assign csFall   = csPrev_reg & ~csS;

  // Pin functions on lines 2 and 3 exist only outside quad and quad-instruction mode
  assign pinFnOn = ~quadEnableBit & ~quadInstructionMode;
  assign pauseFn = pinFnOn & (line3FunctionSelect == `SFPFE_LINE3_PAUSE);
  assign resetFn = pinFnOn & (line3FunctionSelect == `SFPFE_LINE3_RESET);

  // Deselect ends any pause at once
  assign pause_next = pauseFn & ~dSync_reg[3] & ~csS;

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pause_reg <= 1'b0;
    end else begin
      pause_reg <= pause_next;
    end
  end

  // Hardware reset: count a continuous low on line 3, fire once on reaching the minimum
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rstCnt_reg  <= 8'h00;
      hwReset_reg <= 1'b0;
    end else begin
      hwReset_reg <= 1'b0;
      if (resetFn & ~dSync_reg[3]) begin
        if (rstCnt_reg != RESET_CYC[7:0]) begin
          rstCnt_reg <= rstCnt_reg + 8'h01;
        end
        hwReset_reg <= (rstCnt_reg == RESET_CYC[7:0] - 8'h01);
      end else begin
        rstCnt_reg <= 8'h00;
      end
    end
  end

  // Write protect is sampled only while line 2 is not a data line
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wpBlock_reg <= 1'b0;
    end else begin
      wpBlock_reg <= pinFnOn & ~dSync_reg[2] & statusProtectBit;
    end
  end

  // Arming needs a high-to-low select; a hardware reset disarms again
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      armed_reg <= 1'b0;
    end else if (hwReset_reg) begin
      armed_reg <= 1'b0;
    end else if (csFall) begin
      armed_reg <= 1'b1;
    end
  end

  // Frame state is pure interface state: internal cycles live elsewhere and
  // run on through a deselect
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      frameOn_reg    <= 1'b0;
      instrPhase_reg <= 1'b0;
    end else if (hwReset_reg | csS) begin
      frameOn_reg    <= 1'b0;
      instrPhase_reg <= 1'b0;
    end else if (csFall) begin
      frameOn_reg    <= 1'b1;
      instrPhase_reg <= ~contRead;
    end else if (rxTake & (rxCnt_next >= `SFPFE_BYTE_BITS)) begin
      instrPhase_reg <= 1'b0;
    end
  end

  // Edges are frozen in a pause; state is kept so the transfer resumes
  assign liveEdges = frameOn_reg & ~pause_reg & ~csS;

  assign curWidth = quadInstructionMode ? `SFPFE_WIDTH_QUAD :
                    instrPhase_reg ? `SFPFE_WIDTH_SINGLE : cmdWidth;
  assign curBits  = bitsPerClk(curWidth);

  assign rxTake = liveEdges & linkRise & ~txDrive;
  assign txTake = liveEdges & linkFall & txDrive;

  assign rxCnt_next = rxCnt_reg + curBits;

  // Receive shift: lower-numbered lines hold the lower-order bits of each clock's group
  assign rxShift_next = (curWidth == `SFPFE_WIDTH_QUAD) ? {rxShift_reg[3:0], dSync_reg} :
                        (curWidth == `SFPFE_WIDTH_DUAL) ? {rxShift_reg[5:0], dSync_reg[1:0]} :
                        {rxShift_reg[6:0], dSync_reg[0]};

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rxShift_reg <= 8'h00;
      rxCnt_reg   <= 4'h0;
    end else if (hwReset_reg | csS) begin
      rxShift_reg <= 8'h00;
      rxCnt_reg   <= 4'h0;
    end else if (rxTake) begin
      rxShift_reg <= rxShift_next;
      rxCnt_reg   <= (rxCnt_next >= `SFPFE_BYTE_BITS) ? 4'h0 : rxCnt_next;
    end
  end

  // A finished byte waits for the FIFO; a second byte arriving meanwhile is lost
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      push_reg      <= 9'h000;
      pushValid_reg <= 1'b0;
      overrun_reg   <= 1'b0;
    end else begin
      if (pushValid_reg & fifoInReady) begin
        pushValid_reg <= 1'b0;
      end
      if (hwReset_reg) begin
        pushValid_reg <= 1'b0;
        overrun_reg   <= 1'b0;
      end else if (rxTake & (rxCnt_next >= `SFPFE_BYTE_BITS)) begin
        if (pushValid_reg & ~fifoInReady) begin
          overrun_reg <= 1'b1;
        end else begin
          push_reg      <= {instrPhase_reg, rxShift_next};
          pushValid_reg <= 1'b1;
        end
      end else if (csFall) begin
        overrun_reg <= 1'b0;
      end
    end
  end

  sfpfe_fifo #(
    .WIDTH (`SFPFE_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) rxFifo (
    .clk      (sys_clk),
    .nrst     (nrst),
    .inData   (push_reg),
    .inValid  (pushValid_reg),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (rxValid),
    .outReady (rxReady)
  );

  assign rxData  = fifoOut[7:0];
  assign rxInstr = fifoOut[8];

  // Transmit: a new byte is fetched on the falling edge that needs it
  assign txReady = txTake & (txCnt_reg == 4'h0) & txValid;
  assign txSrc   = (txCnt_reg == 4'h0) ? (txValid ? txData : 8'h00) : txShift_reg;

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      txShift_reg <= 8'h00;
      txCnt_reg   <= 4'h0;
      out_reg     <= `SFPFE_OUT_RST;
    end else if (hwReset_reg | csS) begin
      txShift_reg <= 8'h00;
      txCnt_reg   <= 4'h0;
      out_reg     <= `SFPFE_OUT_RST;
    end else if (txTake) begin
      txShift_reg <= txSrc << curBits;
      txCnt_reg   <= (txCnt_reg == 4'h0) ? `SFPFE_BYTE_BITS - curBits : txCnt_reg - curBits;
      case (curWidth)
        `SFPFE_WIDTH_QUAD: out_reg <= txSrc[7:4];
        `SFPFE_WIDTH_DUAL: out_reg <= {2'h0, txSrc[7:6]};
        default:           out_reg <= {2'h0, txSrc[7], 1'b0};
      endcase
    end
  end

  // Drivers off when deselected or paused; single width drives line 1 only
  assign drive       = frameOn_reg & txDrive & ~pause_reg & ~csS;
  assign dataLineOen = drive ? laneOen(curWidth) : `SFPFE_OEN_OFF;
  assign dataLineOut = out_reg;

  assign frameActive        = frameOn_reg;
  assign linkArmed          = armed_reg;
  assign pauseActive        = pause_reg;
  assign hwResetPulse       = hwReset_reg;
  assign statusWriteBlocked = wpBlock_reg;
  assign rxOverrun          = overrun_reg;

endmodule // sfpfe_top

// ==== tb_top.sv ====
// Testbench for the pin front end: host model on the pins, user side driven here.
// Assumes RESET_CYC shortened to 4 and a 20 MHz sys_clk.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk, nrst, quadEnableBit, line3FunctionSelect, quadInstructionMode;
  logic       statusProtectBit, txDrive, contRead, txValid, rxReady;
  logic [1:0] cmdWidth;
  logic [7:0] txData, r, t;
  logic [3:0] s;
  wire  logic [3:0] dataLineOut, dataLineOen, hostData, pins;
  wire  logic [7:0] rxData;
  wire  logic linkClk, chipSelN, txReady, rxInstr, rxValid, frameActive, linkArmed;
  wire  logic pauseActive, hwResetPulse, statusWriteBlocked, rxOverrun;
  int fails = 0;
  int nChecks = 0;
  int nRst = 0;
  // Each line carries the device where its enable is low, else the host
  assign pins = (dataLineOut & ~dataLineOen) | (hostData & dataLineOen);
  sfpfe_top #(.RESET_CYC(4)) uut (
    .sys_clk, .nrst, .linkClk, .chipSelN, .dataLineIn(pins), .dataLineOut, .dataLineOen,
    .quadEnableBit, .line3FunctionSelect, .quadInstructionMode, .statusProtectBit,
    .cmdWidth, .txDrive, .contRead, .txData, .txValid, .txReady, .rxData, .rxInstr,
    .rxValid, .rxReady, .frameActive, .linkArmed, .pauseActive, .hwResetPulse,
    .statusWriteBlocked, .rxOverrun
  );
  sfpfe_host_model host (.clk(sys_clk), .pins, .linkClk, .chipSelN, .hostData);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (hwResetPulse === 1'b1) nRst++;
  task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic pop(input logic [7:0] d, input logic ins);
    int k;
    k = 0;
    @(negedge sys_clk);
    while (rxValid !== 1'b1 && k < 200) begin
      @(negedge sys_clk);
      k++;
    end
    check("rxData", rxData, d);
    check("rxInstr", rxInstr, ins);
    @(posedge sys_clk) rxReady <= 1'b1;
    @(posedge sys_clk) rxReady <= 1'b0;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #4000000;
    fails++;
    test_done();
  end
  initial begin
    {quadEnableBit, line3FunctionSelect, quadInstructionMode, statusProtectBit} = 4'h0;
    {txDrive, contRead, txValid, rxReady} = 4'h0;
    cmdWidth = 2'h1;
    txData = 8'h00;
    nrst = 1'b0;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    host.xfer(8'h3c, 1, r);
    @(negedge sys_clk);
    check("linkArmed", linkArmed, 1'b0);
    check("rxValid", rxValid, 1'b0);
    // Instruction paused mid-byte while the host keeps clocking
    @(posedge sys_clk);
    host.select();
    t = 8'h5a;
    for (int i = 0; i < 12; i++) begin
      if (i > 3 && i < 8) host.tick({3'b011, i[0]}, s);
      else begin
        host.tick({3'b111, t[7]}, s);
        t = t << 1;
      end
      if (i == 5) check("pauseActive", pauseActive, 1'b1);
    end
    host.xfer(8'h6c, 2, r);
    pop(8'h5a, 1'b1);
    pop(8'h6c, 1'b0);
    host.release_bus();
    // Read data out at each width after one leading falling edge
    for (int m = 0; m < 3; m++) begin
      cmdWidth <= m[1:0];
      quadEnableBit <= (m == 2);
      txData <= 8'h81 + 8'(m);
      txDrive <= 1'b1;
      txValid <= 1'b1;
      // Skip the instruction phase so the chosen width applies from the first edge
      contRead <= 1'b1;
      host.select();
      host.tick(4'hf, s);
      @(negedge sys_clk);
      check("dataLineOen", dataLineOen, m == 0 ? 4'hd : (m == 1 ? 4'hc : 4'h0));
      @(posedge sys_clk);
      host.xfer(8'h00, 1 << m, r);
      check("txByte", r, 8'h81 + 8'(m));
      txDrive <= 1'b0;
      txValid <= 1'b0;
      host.release_bus();
    end
    statusProtectBit <= 1'b1;
    contRead <= 1'b0;
    host.hostData <= 4'hb;
    repeat (8) @(negedge sys_clk);
    check("statusWriteBlocked", statusWriteBlocked, 1'b0);
    @(posedge sys_clk);
    quadEnableBit <= 1'b0;
    repeat (8) @(negedge sys_clk);
    check("statusWriteBlocked", statusWriteBlocked, 1'b1);
    // Line 3 held low: no effect in quad, reset with select bit 1
    @(posedge sys_clk);
    quadEnableBit <= 1'b1;
    host.select();
    host.hostData <= 4'h7;
    repeat (12) @(negedge sys_clk);
    check("pauseActive", pauseActive, 1'b0);
    check("nRst", 8'(nRst), 8'h00);
    @(posedge sys_clk);
    quadEnableBit <= 1'b0;
    line3FunctionSelect <= 1'b1;
    repeat (12) @(negedge sys_clk);
    check("nRst", 8'(nRst), 8'h01);
    check("linkArmed", linkArmed, 1'b0);
    @(posedge sys_clk);
    host.hostData <= 4'hf;
    host.release_bus();
    // Instruction in two quad clocks, then fill past the buffer with no pops
    {quadInstructionMode, quadEnableBit, line3FunctionSelect} <= 3'b110;
    cmdWidth <= 2'h2;
    host.select();
    for (int i = 0; i < 10; i++) host.xfer(8'h10 + 8'(i), 4, r);
    check("rxOverrun", rxOverrun, 1'b1);
    for (int i = 0; i < 9; i++) pop(8'h10 + 8'(i), i == 0);
    @(negedge sys_clk);
    check("rxValid", rxValid, 1'b0);
    host.release_bus();
    // Continuous read starts straight at the address
    {quadInstructionMode, contRead} <= 2'b01;
    host.select();
    host.xfer(8'hc3, 4, r);
    pop(8'hc3, 1'b0);
    host.release_bus();
    test_done();
  end
endmodule // tb_top
